/* File: pkg/cmd_defines.vh */
// Register offsets, field positions, command codes and status, interrupt and bus codes of the common command block
`ifndef CMD_DEFINES_VH
`define CMD_DEFINES_VH
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_SRE 8'h08
`define OFS_STB 8'h0C
`define OFS_RESP 8'h10
`define OFS_INT_STAT 8'h14
`define OFS_INT_MASK 8'h18
`define OFS_VTRIG 8'h1C
`define OFS_CTRIG 8'h20
`define OFS_VOUT 8'h24
`define OFS_COUT 8'h28
`define OFS_STATUS_IN 8'h2C
`define OFS_TEST_IN 8'h30
`define OFS_OPERATION_SUMMARY_BIT 8'h34
// Control fields
`define CTRL_CONT 0
`define CTRL_SRC_BUS 1
`define CTRL_OUT_ON 2
`define CTRL_LISTEN 3
// Command codes written to the command register
`define CMD_NOP 4'h0
`define CMD_SRE_Q 4'h1
`define CMD_STB_Q 4'h2
`define CMD_POLL 4'h3
`define CMD_TRG 4'h4
`define CMD_INIT 4'h5
`define CMD_ABORT 4'h6
`define CMD_TST_Q 4'h7
`define CMD_DIAG_Q 4'h8
`define CMD_WAIT 4'h9
`define CMD_GET 4'hA
// Status byte bit and operation summary register bit
`define STB_SUMMARY 6
`define OPERATION_SUMMARY_BIT_WTG 5
// Self-test masks: basic test covers bits 0,1,2,4; extended adds 5,6,7
`define TST_BASIC_MASK 8'h17
`define TST_DIAG_MASK 8'hF7
// Interrupt status bits
`define IRQ_TRIG 0
`define IRQ_RESP 1
`define IRQ_POLL 2
`define IRQ_WAIT 3
`define IRQ_COUNT 4
// Cycle limit for wait-to-continue
`define WAIT_TIMEOUT 16'hFFFF
`define RESP_DIGITS 3
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

/* File: verilog/status_trigger_cmds.v */
// Common command interpreter: status byte, service request, bus trigger, self test and wait-to-continue
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "cmd_defines.vh"

// Notes on behaviour
// - Enable-mask query returns the eight-bit service request enable mask, 0 to 191, bit 6 always clear.
// - Status-byte query returns the byte with summary at bit 6; no bit cleared.
// - Status bits follow their causes; summary set while any service reason exists.
// - Serial poll returns byte with request bit at bit 6, then clears request bit.
// - Bus trigger fires only when armed, source is bus, and waiting bit is set.
// - Continuous arm keeps trigger armed; otherwise arm command arms one trigger.
// - Bus trigger while unarmed produces nothing and logs no error.
// - Firing applies stored triggered levels to output and clears waiting bit.
// - With continuous arm, trigger rearms at once and waiting bit is set again.
// - Bus trigger or group trigger acts only while addressed as listener.
// - Bus trigger ignored while the output is switched off.
// - Self test returns zero on pass, else nonzero code up to 23, or up to 247 from the extended query.
// - All subtests run; each failure sets its own bit; code accumulates.
// - Basic code bits: 1 program memory, 2 working memory, 4 storage, 16 analog.
// - Bits 32, 64, 128 come only from the extended diagnostic query.
// - Wait-to-continue holds later commands until earlier work and level changes finish.
// - Summary bit is OR of enabled status bits; mask bit 6 not programmable.
// - Status byte layout: 7 operation_summary_bit, 5 event, 4 message, 3 questionable, 2 errors, 1 list, 0 busy.
module status_trigger_cmds (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire level_settled,
   output reg [15:0] volt_out,
   output reg [15:0] curr_out,
   output reg trigger_pulse,
   output reg irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;

   reg [3:0] ctrl_q;
   reg [7:0] sre_q;
   reg [7:0] stat_in_q;
   reg [7:0] test_in_q;
   reg [15:0] vtrig_q;
   reg [15:0] ctrig_q;
   reg armed_q;
   reg wtg_q;
   reg rqs_q;
   reg [23:0] resp_q;
   reg resp_valid_q;
   wire [3:0] int_stat;
   reg [3:0] int_mask_q;
   reg [1:0] state_q;
   reg [15:0] wait_cnt_q;
   reg [3:0] held_cmd_q;
   reg held_q;
   reg [2:0] settled_sync_q;
   reg settled_q;
   reg aw_done_q;
   reg w_done_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Three ASCII decimal digits, hundreds in the top byte
   function [23:0] to_ascii;
      input [7:0] v;
      reg [7:0] h;
      reg [7:0] t;
      reg [7:0] u;
      begin
         h = v / 8'd100;
         t = (v % 8'd100) / 8'd10;
         u = v % 8'd10;
         to_ascii = {h + 8'h30, t + 8'h30, u + 8'h30};
      end
   endfunction

   // Strobe for one command code reaching the executor
   function cmd_hit;
      input go;
      input [3:0] code;
      input [3:0] want;
      begin
         cmd_hit = go & (code == want);
      end
   endfunction

   wire [7:0] enabled_bits = stat_in_q & sre_q & ~(8'h01 << `STB_SUMMARY);
   wire summary = |enabled_bits;
   wire [7:0] stb_base = stat_in_q & ~(8'h01 << `STB_SUMMARY);
   wire [7:0] stb_mss = stb_base | ({7'h00, summary} << `STB_SUMMARY);
   wire [7:0] stb_rqs = stb_base | ({7'h00, rqs_q} << `STB_SUMMARY);

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   wire wr_go = aw_done_q & w_done_q & ~s_axi_bvalid;
   wire rd_go = s_axi_arvalid & s_axi_arready;
   wire [3:0] cmd_in = wdata_q[3:0];
   wire cmd_wr = wr_go & (awaddr_q == `OFS_CMD);
   wire exec_busy = (state_q == ST_WAIT);
   // Command reaching the executor: new one, or one held behind a wait
   wire [3:0] exec_cmd = (held_q & ~exec_busy) ? held_cmd_q : cmd_in;
   wire exec_go = (held_q & ~exec_busy) | (cmd_wr & ~exec_busy & ~held_q);
   wire wr_stall = cmd_wr & held_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_done_q <= 1'b0;
         w_done_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AXI_OKAY;
      end else begin
         s_axi_awready <= ~aw_done_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_done_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_done_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_done_q <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         // A command write while another is held stalls until it can be queued
         if (wr_go & ~wr_stall) begin
            aw_done_q <= 1'b0;
            w_done_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q > `OFS_TEST_IN) ? `AXI_SLVERR : `AXI_OKAY;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            case (s_axi_araddr)
               `OFS_CTRL: s_axi_rdata <= {28'h0, ctrl_q};
               `OFS_SRE: s_axi_rdata <= {24'h0, sre_q};
               `OFS_STB: s_axi_rdata <= {24'h0, stb_mss};
               `OFS_RESP: s_axi_rdata <= {7'h0, resp_valid_q, resp_q};
               `OFS_INT_STAT: s_axi_rdata <= {28'h0, int_stat};
               `OFS_INT_MASK: s_axi_rdata <= {28'h0, int_mask_q};
               `OFS_VTRIG: s_axi_rdata <= {16'h0, vtrig_q};
               `OFS_CTRIG: s_axi_rdata <= {16'h0, ctrig_q};
               `OFS_VOUT: s_axi_rdata <= {16'h0, volt_out};
               `OFS_COUT: s_axi_rdata <= {16'h0, curr_out};
               `OFS_STATUS_IN: s_axi_rdata <= {24'h0, stat_in_q};
               `OFS_TEST_IN: s_axi_rdata <= {24'h0, test_in_q};
               `OFS_OPERATION_SUMMARY_BIT: s_axi_rdata <= {26'h0, wtg_q, 1'b0, armed_q, held_q, exec_busy, 1'b0};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `AXI_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Settled input synchroniser
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         settled_sync_q <= 3'b000;
         settled_q <= 1'b0;
      end else begin
         settled_sync_q <= {settled_sync_q[1:0], level_settled};
         // A change counts once the second and third stages agree
         if (settled_sync_q[1] == settled_sync_q[2]) begin
            settled_q <= settled_sync_q[2];
         end
      end
   end

   // ------------------------------------------------------------
   // Command execution
   // ------------------------------------------------------------
   wire cfg_wr = wr_go & ~wr_stall;
   wire trg_cmd = cmd_hit(exec_go, exec_cmd, `CMD_TRG) | cmd_hit(exec_go, exec_cmd, `CMD_GET);
   wire trg_fire = trg_cmd & ctrl_q[`CTRL_LISTEN] & ctrl_q[`CTRL_OUT_ON]
                   & ctrl_q[`CTRL_SRC_BUS] & armed_q & wtg_q;
   wire poll_go = cmd_hit(exec_go, exec_cmd, `CMD_POLL);
   wire init_go = cmd_hit(exec_go, exec_cmd, `CMD_INIT);
   wire abort_go = cmd_hit(exec_go, exec_cmd, `CMD_ABORT);
   wire wait_go = cmd_hit(exec_go, exec_cmd, `CMD_WAIT);
   wire resp_rd = rd_go & (s_axi_araddr == `OFS_RESP);
   wire resp_set = cmd_hit(exec_go, exec_cmd, `CMD_SRE_Q) | cmd_hit(exec_go, exec_cmd, `CMD_STB_Q) | poll_go
                   | cmd_hit(exec_go, exec_cmd, `CMD_TST_Q) | cmd_hit(exec_go, exec_cmd, `CMD_DIAG_Q);
   wire wait_done = exec_busy & (settled_q | (wait_cnt_q == `WAIT_TIMEOUT));
   wire [3:0] ev = {wait_done, poll_go, resp_set, trg_fire};
   wire int_clr_wr = cfg_wr & (awaddr_q == `OFS_INT_STAT);

   // ------------------------------------------------------------
   // Configuration and service request
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= 4'h0;
         sre_q <= 8'h00;
         stat_in_q <= 8'h00;
         test_in_q <= 8'h00;
         vtrig_q <= 16'h0000;
         ctrig_q <= 16'h0000;
         int_mask_q <= 4'h0;
         rqs_q <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (cfg_wr) begin
            case (awaddr_q)
               `OFS_CTRL: ctrl_q <= wdata_q[3:0];
               `OFS_SRE: sre_q <= wdata_q[7:0] & ~(8'h01 << `STB_SUMMARY);
               `OFS_INT_MASK: int_mask_q <= wdata_q[3:0];
               `OFS_VTRIG: vtrig_q <= wdata_q[15:0];
               `OFS_CTRIG: ctrig_q <= wdata_q[15:0];
               `OFS_STATUS_IN: stat_in_q <= wdata_q[7:0];
               `OFS_TEST_IN: test_in_q <= wdata_q[7:0];
               default: ;
            endcase
         end
         // Service request: raised by summary, cleared by poll
         if (summary & ~rqs_q) begin
            rqs_q <= 1'b1;
         end else if (poll_go) begin
            rqs_q <= 1'b0;
         end
         irq <= |(int_stat & int_mask_q);
      end
   end

   // ------------------------------------------------------------
   // Trigger arming and output levels
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         armed_q <= 1'b0;
         wtg_q <= 1'b0;
         volt_out <= 16'h0000;
         curr_out <= 16'h0000;
         trigger_pulse <= 1'b0;
      end else begin
         trigger_pulse <= trg_fire;
         // Arming and waiting bit
         if (ctrl_q[`CTRL_CONT]) begin
            armed_q <= 1'b1;
            wtg_q <= ctrl_q[`CTRL_SRC_BUS];
         end else if (trg_fire) begin
            armed_q <= 1'b0;
            wtg_q <= 1'b0;
         end else if (init_go) begin
            armed_q <= 1'b1;
            wtg_q <= 1'b1;
         end else if (abort_go) begin
            armed_q <= 1'b0;
            wtg_q <= 1'b0;
         end
         if (trg_fire) begin
            volt_out <= vtrig_q;
            curr_out <= ctrig_q;
         end
      end
   end

   // ------------------------------------------------------------
   // Query answers
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         resp_q <= 24'h000000;
         resp_valid_q <= 1'b0;
      end else begin
         if (exec_go) begin
            case (exec_cmd)
               `CMD_SRE_Q: resp_q <= to_ascii(sre_q);
               `CMD_STB_Q: resp_q <= to_ascii(stb_mss);
               `CMD_POLL: resp_q <= to_ascii(stb_rqs);
               `CMD_TST_Q: resp_q <= to_ascii(test_in_q & `TST_BASIC_MASK);
               `CMD_DIAG_Q: resp_q <= to_ascii(test_in_q & `TST_DIAG_MASK);
               default: ;
            endcase
         end
         if (resp_set) begin
            resp_valid_q <= 1'b1;
         end else if (resp_rd) begin
            resp_valid_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Wait-to-continue sequencing
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
         wait_cnt_q <= 16'h0000;
         held_cmd_q <= `CMD_NOP;
         held_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               wait_cnt_q <= 16'h0000;
               if (wait_go) begin
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               wait_cnt_q <= wait_cnt_q + 16'h0001;
               if (wait_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
         if (cmd_wr & exec_busy & ~held_q) begin
            held_q <= 1'b1;
            held_cmd_q <= cmd_in;
         end else if (held_q & ~exec_busy) begin
            held_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt status, one sticky bit per event
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_COUNT; gi = gi + 1) begin : g_int
         reg flag_q;
         always @(posedge aclk) begin
            if (!aresetn) begin
               flag_q <= 1'b0;
            end else if (ev[gi]) begin
               flag_q <= 1'b1; // Set wins over write-one-to-clear
            end else if (int_clr_wr & wdata_q[gi]) begin
               flag_q <= 1'b0;
            end
         end
         assign int_stat[gi] = flag_q;
      end
   endgenerate

endmodule

/* File: dv/status_trigger_cmds_properties.sv */
// Port checker of the common command interpreter
`timescale 1ns/1ns
`include "cmd_defines.vh"
module status_trigger_cmds_checker (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [15:0] volt_out,
   input wire trigger_pulse
);
   reg [7:0] raddr_q;
   // Remembers which register the pending read answers
   always @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) raddr_q <= s_axi_araddr;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer moved");
   AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_AW_TAKEN: assert property ($rose(s_axi_awvalid) |-> ##[1:2] s_axi_awready)
      else $error("write address not taken");
   AST_PULSE_ONE: assert property (trigger_pulse |=> !trigger_pulse)
      else $error("trigger pulse too long");
   AST_LEVEL_ON_TRIG: assert property (!$stable(volt_out) |-> ##[0:2] trigger_pulse)
      else $error("level moved without trigger");
   AST_MASK_BIT6: assert property (s_axi_rvalid && raddr_q == `OFS_SRE |-> !s_axi_rdata[6])
      else $error("mask bit 6 set");
   AST_RESP_ASCII: assert property (s_axi_rvalid && raddr_q == `OFS_RESP && s_axi_rdata[24] |->
      s_axi_rdata[23:20] == 4'h3 && s_axi_rdata[15:12] == 4'h3 && s_axi_rdata[7:4] == 4'h3)
      else $error("answer not decimal text");
endmodule
bind status_trigger_cmds status_trigger_cmds_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .volt_out, .trigger_pulse);

/* File: dv/level_stage_model.sv */
// Output stage model: level settles a while after each change
`timescale 1ns/1ns
module level_stage_model #(parameter int SETTLE = 40) (
   input wire logic aclk,
   input wire logic [15:0] volt_out,
   output logic level_settled
);
   logic [15:0] last_q = 16'h0000;
   int cnt_q = 0;
   always @(posedge aclk) begin
      last_q <= volt_out;
      if (volt_out != last_q) cnt_q <= SETTLE;
      else if (cnt_q > 0) cnt_q <= cnt_q - 1;
   end
   assign level_settled = (cnt_q == 0);
endmodule

/* File: dv/status_trigger_cmds_tb_top.sv */
// Self-checking bench of the common command interpreter
`timescale 1ns/1ns
`include "cmd_defines.vh"
module status_trigger_cmds_tb_top;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] awaddr = 0;
   logic [7:0] araddr = 0;
   logic [31:0] wdata = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, settled, tpulse, irq;
   logic [1:0] bresp, rresp, rr, wb;
   logic [31:0] rdata, d;
   logic [15:0] vout, cout;
   int n_fail = 0, cmp_count = 0, cyc = 0, i, n_pulse = 0;
   logic [7:0] tv [4] = '{8'h00, 8'hFF, 8'h21, 8'h48};
   logic [31:0] ctl [4] = '{32'h6, 32'hA, 32'hC, 32'hE};
   logic [3:0] pre [4] = '{`CMD_NOP, `CMD_NOP, `CMD_NOP, `CMD_ABORT};
   status_trigger_cmds u_status_trigger_cmds (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .level_settled(settled), .volt_out(vout), .curr_out(cout), .trigger_pulse(tpulse), .irq(irq));
   level_stage_model #(.SETTLE(80)) u_level_stage_model (.aclk(aclk), .volt_out(vout), .level_settled(settled));
   initial forever #5 aclk = ~aclk;
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict;
      end
   end
   always @(posedge aclk) begin
      if (tpulse) n_pulse <= n_pulse + 1;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   // ----------------------------------------
   // Register access tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      wb = bresp;
      bready <= 0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      d = rdata;
      rr = rresp;
      rready <= 0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rdr(a);
      chk(d & m, e);
   endtask
   task automatic cmd(input logic [3:0] c);
      wr(`OFS_CMD, {28'h0, c});
   endtask
   task automatic resp(input int e);
      int t;
      t = 0;
      d = 0;
      while (!d[24] && t < 60) begin
         rdr(`OFS_RESP);
         t++;
      end
      chk(d, {8'h01, 8'h30 + 8'(e / 100), 8'h30 + 8'((e / 10) % 10), 8'h30 + 8'(e % 10)});
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      wr(`OFS_SRE, 32'hFF);
      chk(wb, `AXI_OKAY);
      rc(`OFS_SRE, 32'hFF, 32'hBF);
      cmd(`CMD_SRE_Q);
      resp(191);
      rc(`OFS_RESP, 32'h01000000, 0);
      rdr(8'h3C);
      chk(d, 0);
      chk(rr, `AXI_SLVERR);
      wr(8'h3C, 32'h1);
      chk(wb, `AXI_SLVERR);
      $display("mask test done");
      wr(`OFS_STATUS_IN, 32'hD8);
      wr(`OFS_SRE, 32'h10);
      for (i = 0; i < 2; i++) rc(`OFS_STB, 32'hFF, 32'hD8);
      cmd(`CMD_STB_Q);
      resp(216);
      cmd(`CMD_POLL);
      resp(216);
      wr(`OFS_SRE, 32'h0);
      rc(`OFS_STB, 32'hFF, 32'h98);
      cmd(`CMD_POLL);
      resp(216);
      cmd(`CMD_POLL);
      resp(152);
      $display("status test done");
      wr(`OFS_VTRIG, 32'h1234);
      wr(`OFS_CTRIG, 32'h56);
      wr(`OFS_CTRL, 32'hE);
      cmd(`CMD_TRG);
      rc(`OFS_VOUT, 32'hFFFF, 0);
      rc(`OFS_INT_STAT, 32'h1, 0);
      cmd(`CMD_INIT);
      rc(`OFS_OPERATION_SUMMARY_BIT, 32'h28, 32'h28);
      cmd(`CMD_TRG);
      rc(`OFS_VOUT, 32'hFFFF, 32'h1234);
      rc(`OFS_COUT, 32'hFFFF, 32'h56);
      rc(`OFS_OPERATION_SUMMARY_BIT, 32'h28, 0);
      rc(`OFS_INT_STAT, 32'h1, 1);
      chk(irq, 0);
      wr(`OFS_INT_MASK, 32'h1);
      rc(`OFS_INT_MASK, 32'hF, 1);
      chk(irq, 1);
      wr(`OFS_INT_STAT, 32'h1);
      rc(`OFS_INT_STAT, 32'h1, 0);
      chk(irq, 0);
      wr(`OFS_VTRIG, 32'h777);
      cmd(`CMD_TRG);
      rc(`OFS_VOUT, 32'hFFFF, 32'h1234);
      for (i = 0; i < 4; i++) begin
         wr(`OFS_CTRL, 32'hE);
         cmd(`CMD_INIT);
         cmd(pre[i]);
         wr(`OFS_CTRL, ctl[i]);
         cmd(`CMD_TRG);
         rc(`OFS_VOUT, 32'hFFFF, 32'h1234);
      end
      wr(`OFS_CTRL, 32'hE);
      cmd(`CMD_INIT);
      cmd(`CMD_GET);
      rc(`OFS_VOUT, 32'hFFFF, 32'h777);
      wr(`OFS_VTRIG, 32'h321);
      wr(`OFS_CTRL, 32'hF);
      rc(`OFS_OPERATION_SUMMARY_BIT, 32'h20, 32'h20);
      cmd(`CMD_TRG);
      rc(`OFS_VOUT, 32'hFFFF, 32'h321);
      rc(`OFS_OPERATION_SUMMARY_BIT, 32'h20, 32'h20);
      cmd(`CMD_WAIT);
      cmd(`CMD_SRE_Q);
      rc(`OFS_RESP, 32'h01000000, 0);
      rc(`OFS_OPERATION_SUMMARY_BIT, 32'h4, 32'h4);
      resp(0);
      chk(n_pulse, 3);
      $display("trigger test done");
      for (i = 0; i < 4; i++) begin
         wr(`OFS_TEST_IN, {24'h0, tv[i]});
         cmd(`CMD_TST_Q);
         resp(tv[i] & 8'h17);
         cmd(`CMD_DIAG_Q);
         resp(tv[i] & 8'hF7);
      end
      $display("self test done");
      give_verdict;
   end
endmodule
